/* File: hdl/tec_consts.svh */
// Purpose: offsets, field positions, reset values and codes of the timer/event counter
// Assumes: byte addresses on an 8-bit register address, 16-bit data
// Notes: definitions only
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TEC_OFF_TIMER_CTRL 8'h00
`define TEC_OFF_PRESCALE_SEL 8'h04
`define TEC_OFF_CAPCMP_CTRL 8'h08
`define TEC_OFF_EDGE_MODE 8'h0c
`define TEC_OFF_SAMPLE_SEL 8'h10
`define TEC_OFF_MATCH_A 8'h14
`define TEC_OFF_MATCH_B 8'h18
`define TEC_OFF_CAPTURE_C 8'h1c
`define TEC_OFF_COUNTER 8'h20

// ----------------------------------------
// reset values
// ----------------------------------------
`define TEC_RST_TIMER_CTRL 8'h00
`define TEC_RST_PRESCALE_SEL 8'h11
`define TEC_RST_CAPCMP_CTRL 8'h00
`define TEC_RST_EDGE_MODE 2'h0
`define TEC_RST_SAMPLE_SEL 2'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define TEC_BIT_WIDTH_SEL 0
`define TEC_BIT_WRAP 2
`define TEC_BIT_RUN 3
`define TEC_BIT_CLR_A 0
`define TEC_BIT_CLR_B 1
`define TEC_BIT_B_CAPT 2

// ----------------------------------------
// clock select codes and limits
// ----------------------------------------
`define TEC_CLK_EXT 4'h0
`define TEC_CLK_DIV_FIRST 4'h1
`define TEC_CLK_DIV_LAST 4'h9
`define TEC_DIV_STAGES 10
`define TEC_SMP_DIV32 5
`define TEC_SMP_DIV64 6
`define TEC_SMP_DIV128 7
`define TEC_NARROW_MAX 16'h00ff
`define TEC_WIDE_MAX 16'hffff

`endif

/* File: hdl/tec_pkg.sv */
// Purpose: types shared by the timer/event counter files
// Assumes: nothing beyond the constants header
// Notes: types only
package tec_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tec_bus_req_t;

  typedef enum logic [1:0] {
    TEC_EDGE_FALL,
    TEC_EDGE_RISE,
    TEC_EDGE_BOTH,
    TEC_EDGE_BOTH_ALT
  } tec_edge_mode_t;

  typedef enum logic [1:0] {
    TEC_ST_STOPPED,
    TEC_ST_ARMED,
    TEC_ST_COUNTING
  } tec_run_state_t;

endpackage : tec_pkg

/* File: hdl/tec_prescaler.sv */
// Purpose: free-running divider giving one-cycle ticks at sys_clk / 2^k
// Assumes: synchronous reset copy from the top
// Notes: tick k fires once every 2^k cycles
`timescale 1ns/1ps
`default_nettype none
`include "tec_consts.svh"
module tec_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // divided ticks
  output logic [`TEC_DIV_STAGES:1] tick
);
  logic [`TEC_DIV_STAGES-1:0] div_cnt;
  logic [`TEC_DIV_STAGES:1] next_tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  genvar k;
  generate
    for (k = 1; k <= `TEC_DIV_STAGES; k++) begin : g_tick
      assign next_tick[k] = &div_cnt[k-1:0];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= '0;
    end else begin
      tick <= next_tick;
    end
  end
endmodule : tec_prescaler
`default_nettype wire

/* File: hdl/tec_edge_detect.sv */
// Purpose: synchronise the external pin, filter it at the sampling rate, flag valid edges
// Assumes: sample_en is a one-cycle pulse on clk, or held high to sample every cycle
// Notes: a level counts only after three equal samples
`timescale 1ns/1ps
`default_nettype none
module tec_edge_detect
  import tec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and settings
  input wire logic pin_in,
  input wire logic sample_en,
  input wire tec_edge_mode_t edge_mode,
  // result
  output logic edge_pulse
);
  logic sync_a;
  logic sync_b;
  logic [1:0] hist;
  logic level;
  logic next_pulse;
  logic stable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  // shorter pulses than three samples are dropped on purpose
  assign stable = (hist[0] == sync_b) && (hist[1] == sync_b);

  always_comb begin
    next_pulse = 1'b0;
    if (sample_en && stable && (sync_b != level)) begin
      case (edge_mode)
        TEC_EDGE_FALL: next_pulse = !sync_b;
        TEC_EDGE_RISE: next_pulse = sync_b;
        default: next_pulse = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist <= 2'h0;
      level <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      if (sample_en) begin
        hist <= {hist[0], sync_b};
        if (stable) begin
          level <= sync_b;
        end
      end
      edge_pulse <= next_pulse;
    end
  end
endmodule : tec_edge_detect
`default_nettype wire

/* File: hdl/tec_core.sv */
// Purpose: 8/16-bit up-counting timer/event counter with prescaler, edge detector, selector
// Assumes: one 100 MHz sys_clk; plain register port, read data one cycle after the strobe
// Notes: the count clock is a one-cycle enable; nothing runs on a second clock
`timescale 1ns/1ps
`default_nettype none
`include "tec_consts.svh"

// What this block does
// - a valid pin edge gives interrupt request, capture trigger and event tick together
// - prescaler divides sys_clk; selector picks a divided tick or the pin edge
// - only the low nibble of timer_ctrl_reg steers this counter
// - timer_ctrl_reg resets to zero, counter stopped, narrow mode
// - prescale_sel_reg low nibble picks the count clock; resets to 11 hex
// - capcmp_ctrl_reg picks compare or capture for b and clear enables; resets zero
// - width_sel bit 0 selects 8-bit when 0, 16-bit when 1
// - setting count_run loads zero on the next count tick, then increments
// - clearing count_run zeroes the counter at once and stops capture and match
// - writing count_run 1 while running leaves counting undisturbed
// - tick at all ones wraps to zero, sets wrap_flag, keeps counting
// - wrap_flag stays set until software or reset clears it
// - reset zeroes the counter and stops counting
// - wide mode makes counter, match_a and match_or_capture_b 16 bits
// - enabled match or capture clears counter on the next tick, holding till then
// - restart after a stop always begins from zero at the first tick after set
// - selecting the pin edge as count clock makes it an event counter
// - sample_clk_sel_reg picks sampling at cpu clock, /32, /64 or /128
// - event rate limit follows the sampling clock, same for one or both edges
// - match_a equal to the counter raises match_a_irq, may clear counter
// - match_or_capture_b acts as compare or capture per capcmp_ctrl_reg
// - each capture trigger loads capture_c, held until the next trigger
module tec_core
  import tec_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire tec_bus_req_t bus_req,
  output logic [15:0] rdata,
  // external pin
  input wire logic ext_irq_pin,
  // event outputs
  output logic ext_irq_req,
  output logic match_a_irq,
  output logic match_b_irq
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic width_eq(input logic [15:0] a, input logic [15:0] b,
                                    input logic wide);
    if (wide) begin
      width_eq = (a == b);
    end else begin
      width_eq = (a[7:0] == b[7:0]);
    end
  endfunction : width_eq

  function automatic logic is_write(input tec_bus_req_t req, input logic [7:0] off);
    is_write = req.wr && (req.addr == off);
  endfunction : is_write

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic width_sel;
  logic count_run;
  logic wrap_flag;
  logic [3:0] ctrl_upper;
  logic [7:0] prescale_sel_reg;
  logic [7:0] capcmp_ctrl_reg;
  tec_edge_mode_t edge_mode_reg;
  logic [1:0] sample_clk_sel_reg;
  logic [15:0] match_a;
  logic [15:0] match_or_capture_b;
  logic [15:0] capture_c;
  logic [15:0] counter;
  tec_run_state_t run_state;
  logic clear_pending;
  logic counted;

  logic wr_ctrl;
  logic next_run;
  logic wrap_event;
  logic clr_a_en;
  logic clr_b_en;
  logic b_capture;
  logic running;
  logic capture_evt;
  logic clear_source;
  logic [15:0] count_max;

  assign wr_ctrl = is_write(bus_req, `TEC_OFF_TIMER_CTRL);
  assign next_run = wr_ctrl ? bus_req.wdata[`TEC_BIT_RUN] : count_run;
  assign clr_a_en = capcmp_ctrl_reg[`TEC_BIT_CLR_A];
  assign clr_b_en = capcmp_ctrl_reg[`TEC_BIT_CLR_B];
  assign b_capture = capcmp_ctrl_reg[`TEC_BIT_B_CAPT];
  assign running = (run_state != TEC_ST_STOPPED);
  assign count_max = width_sel ? `TEC_WIDE_MAX : `TEC_NARROW_MAX;

  // timer control: upper nibble is kept for the neighbour counter and read back only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      width_sel <= 1'(`TEC_RST_TIMER_CTRL >> `TEC_BIT_WIDTH_SEL);
      count_run <= 1'b0;
      ctrl_upper <= 4'h0;
    end else if (wr_ctrl) begin
      width_sel <= bus_req.wdata[`TEC_BIT_WIDTH_SEL];
      count_run <= bus_req.wdata[`TEC_BIT_RUN];
      ctrl_upper <= bus_req.wdata[7:4];
    end
  end

  // a hardware wrap in the same cycle as a software clear wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_flag <= 1'b0;
    end else if (wrap_event) begin
      wrap_flag <= 1'b1;
    end else if (wr_ctrl && !bus_req.wdata[`TEC_BIT_WRAP]) begin
      wrap_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_sel_reg <= `TEC_RST_PRESCALE_SEL;
      capcmp_ctrl_reg <= `TEC_RST_CAPCMP_CTRL;
      edge_mode_reg <= tec_edge_mode_t'(`TEC_RST_EDGE_MODE);
      sample_clk_sel_reg <= `TEC_RST_SAMPLE_SEL;
    end else begin
      if (is_write(bus_req, `TEC_OFF_PRESCALE_SEL)) begin
        prescale_sel_reg <= bus_req.wdata[7:0];
      end
      if (is_write(bus_req, `TEC_OFF_CAPCMP_CTRL)) begin
        capcmp_ctrl_reg <= {5'h00, bus_req.wdata[2:0]};
      end
      if (is_write(bus_req, `TEC_OFF_EDGE_MODE)) begin
        edge_mode_reg <= tec_edge_mode_t'(bus_req.wdata[1:0]);
      end
      if (is_write(bus_req, `TEC_OFF_SAMPLE_SEL)) begin
        sample_clk_sel_reg <= bus_req.wdata[1:0];
      end
    end
  end

  // compare value a; b is writable by software only while it acts as compare
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_a <= 16'h0000;
    end else if (is_write(bus_req, `TEC_OFF_MATCH_A)) begin
      match_a <= width_sel ? bus_req.wdata : {8'h00, bus_req.wdata[7:0]};
    end
  end

  // ----------------------------------------
  // prescaler, edge detector, selector
  // ----------------------------------------
  logic [`TEC_DIV_STAGES:1] div_tick;
  logic sample_tick;
  logic ext_edge;
  logic count_tick;
  logic [3:0] clk_code;

  tec_prescaler u_prescaler (
    .clk(sys_clk),
    .rst_n(rst_n),
    .tick(div_tick)
  );

  // the cpu clock equals sys_clk here, so that choice samples every cycle
  always_comb begin
    case (sample_clk_sel_reg)
      2'h0: sample_tick = 1'b1;
      2'h1: sample_tick = div_tick[`TEC_SMP_DIV32];
      2'h2: sample_tick = div_tick[`TEC_SMP_DIV64];
      default: sample_tick = div_tick[`TEC_SMP_DIV128];
    endcase
  end

  tec_edge_detect u_edge (
    .clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(ext_irq_pin),
    .sample_en(sample_tick),
    .edge_mode(edge_mode_reg),
    .edge_pulse(ext_edge)
  );

  assign clk_code = prescale_sel_reg[3:0];

  // unused codes give no count clock at all rather than a guessed rate
  always_comb begin
    count_tick = 1'b0;
    if (clk_code == `TEC_CLK_EXT) begin
      count_tick = ext_edge;
    end else if (clk_code >= `TEC_CLK_DIV_FIRST && clk_code <= `TEC_CLK_DIV_LAST) begin
      count_tick = div_tick[clk_code + 4'h1];
    end
  end

  // request leaves with the capture trigger and tick, not a cycle behind them
  assign ext_irq_req = ext_edge;

  // ----------------------------------------
  // run state
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_state <= TEC_ST_STOPPED;
    end else begin
      case (run_state)
        TEC_ST_STOPPED: begin
          if (next_run) begin
            run_state <= TEC_ST_ARMED;
          end
        end
        TEC_ST_ARMED: begin
          if (!next_run) begin
            run_state <= TEC_ST_STOPPED;
          end else if (count_tick) begin
            run_state <= TEC_ST_COUNTING;
          end
        end
        TEC_ST_COUNTING: begin
          if (!next_run) begin
            run_state <= TEC_ST_STOPPED;
          end
        end
        default: run_state <= TEC_ST_STOPPED;
      endcase
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  assign wrap_event = (run_state == TEC_ST_COUNTING) && next_run && count_tick &&
                      !clear_pending && (counter == count_max);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter <= 16'h0000;
    end else if (!next_run) begin
      counter <= 16'h0000;
    end else if (count_tick && run_state != TEC_ST_STOPPED) begin
      if (run_state == TEC_ST_ARMED) begin
        counter <= 16'h0000;
      end else if (clear_pending) begin
        counter <= 16'h0000;
      end else if (counter == count_max) begin
        counter <= 16'h0000;
      end else begin
        counter <= (counter + 16'h0001) & count_max;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counted <= 1'b0;
    end else begin
      counted <= next_run && count_tick && running;
    end
  end

  // ----------------------------------------
  // compare and capture
  // ----------------------------------------
  logic hit_a;
  logic hit_b;

  assign hit_a = counted && count_run && width_eq(counter, match_a, width_sel);
  assign hit_b = counted && count_run && !b_capture &&
                 width_eq(counter, match_or_capture_b, width_sel);
  assign capture_evt = ext_edge && running && next_run;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
    end else begin
      match_a_irq <= hit_a;
      match_b_irq <= hit_b;
    end
  end

  assign clear_source = (hit_a && clr_a_en) || (hit_b && clr_b_en) ||
                        (capture_evt && b_capture && clr_b_en);

  // a new source in the same cycle as a tick stays pending for the next tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_pending <= 1'b0;
    end else if (!next_run) begin
      clear_pending <= 1'b0;
    end else if (clear_source) begin
      clear_pending <= 1'b1;
    end else if (count_tick) begin
      clear_pending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_or_capture_b <= 16'h0000;
    end else if (capture_evt && b_capture) begin
      match_or_capture_b <= counter;
    end else if (is_write(bus_req, `TEC_OFF_MATCH_B) && !b_capture) begin
      match_or_capture_b <= width_sel ? bus_req.wdata : {8'h00, bus_req.wdata[7:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_c <= 16'h0000;
    end else if (capture_evt) begin
      capture_c <= counter;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    case (bus_req.addr)
      `TEC_OFF_TIMER_CTRL: next_rdata = {8'h00, ctrl_upper, count_run, wrap_flag, 1'b0,
                                         width_sel};
      `TEC_OFF_PRESCALE_SEL: next_rdata = {8'h00, prescale_sel_reg};
      `TEC_OFF_CAPCMP_CTRL: next_rdata = {8'h00, capcmp_ctrl_reg};
      `TEC_OFF_EDGE_MODE: next_rdata = {14'h0000, edge_mode_reg};
      `TEC_OFF_SAMPLE_SEL: next_rdata = {14'h0000, sample_clk_sel_reg};
      `TEC_OFF_MATCH_A: next_rdata = match_a;
      `TEC_OFF_MATCH_B: next_rdata = match_or_capture_b;
      `TEC_OFF_CAPTURE_C: next_rdata = capture_c;
      `TEC_OFF_COUNTER: next_rdata = counter;
      default: next_rdata = 16'h0000;
    endcase
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule : tec_core
`default_nettype wire

/* File: tb/tec_core_properties.sv */
// Purpose: port-level checks of the timer/event counter
// Assumes: bus, pin and event outputs as seen at the tec_core ports
// Notes: run and width are tracked from bus writes, not from inner state
`timescale 1ns/1ps
`default_nettype none
`include "tec_consts.svh"
module tec_core_properties
  import tec_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire tec_bus_req_t bus_req,
  input wire logic [15:0] rdata,
  // pin and events
  input wire logic ext_irq_pin,
  input wire logic ext_irq_req,
  input wire logic match_a_irq,
  input wire logic match_b_irq
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic run_q;
  logic wide_q;
  logic tc_wr;
  logic pm_wr;
  logic pin_q;
  logic [2:0] stop_age;
  logic [9:0] pin_age;
  logic ctl_wr;
  assign ctl_wr = bus_req.wr && bus_req.addr == `TEC_OFF_TIMER_CTRL;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 1'b0;
      wide_q <= 1'b0;
      tc_wr <= 1'b0;
      pm_wr <= 1'b0;
    end else begin
      if (ctl_wr) begin
        run_q <= bus_req.wdata[3];
        wide_q <= bus_req.wdata[0];
        tc_wr <= 1'b1;
      end
      if (bus_req.wr && bus_req.addr == `TEC_OFF_PRESCALE_SEL) begin
        pm_wr <= 1'b1;
      end
    end
  end
  // ages saturate so long idle spells never wrap back into range
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_age <= 3'h7;
      pin_q <= 1'b0;
      pin_age <= 10'h000;
    end else begin
      stop_age <= run_q ? 3'h0 : (stop_age == 3'h7 ? stop_age : stop_age + 3'h1);
      pin_q <= ext_irq_pin;
      pin_age <= (ext_irq_pin != pin_q) ? 10'h000 :
                 (pin_age == 10'h3ff ? pin_age : pin_age + 10'h001);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence rd_at(logic [7:0] a, logic en);
    bus_req.rd && bus_req.addr == a && en;
  endsequence
  edge_pulse_a: assert property (ext_irq_req |=> !ext_irq_req)
    else $error("edge request longer than one cycle");
  edge_cause_a: assert property (ext_irq_req |-> pin_age < 10'h258)
    else $error("edge request without a recent pin change");
  match_pulse_a: assert property (match_a_irq |=> !match_a_irq)
    else $error("match a request longer than one cycle");
  stop_quiet_a: assert property (stop_age >= 3'h3 |-> !match_a_irq && !match_b_irq)
    else $error("match request while stopped");
  ctrl_readback_a: assert property (rd_at(`TEC_OFF_TIMER_CTRL, 1'b1) |=>
    rdata[15:8] == 8'h00 && !rdata[1])
    else $error("timer control reads stray bits");
  ctrl_reset_a: assert property (rd_at(`TEC_OFF_TIMER_CTRL, !tc_wr) |=>
    rdata == 16'h0000)
    else $error("timer control not zero after reset");
  prescale_reset_a: assert property (rd_at(`TEC_OFF_PRESCALE_SEL, !pm_wr) |=>
    rdata == 16'h0011)
    else $error("prescale select not 11 after reset");
  capcmp_bits_a: assert property (rd_at(`TEC_OFF_CAPCMP_CTRL, 1'b1) |=>
    rdata[15:3] == 13'h0000)
    else $error("capture compare control reads stray bits");
  narrow_count_a: assert property (rd_at(`TEC_OFF_COUNTER, !wide_q) |=>
    rdata[15:8] == 8'h00)
    else $error("narrow counter above ff");
  stop_zero_a: assert property (rd_at(`TEC_OFF_COUNTER, !run_q) |=>
    rdata == 16'h0000)
    else $error("counter not zero while stopped");
endmodule : tec_core_properties
bind tec_core tec_core_properties u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .bus_req(bus_req), .rdata(rdata), .ext_irq_pin(ext_irq_pin), .ext_irq_req(ext_irq_req),
  .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
`default_nettype wire

/* File: tb/tec_pulse_src.sv */
// Purpose: external pulse source on the event pin
// Assumes: go held until done is seen high
// Notes: one pulse, high for half cycles then low for half cycles; idle low
`timescale 1ns/1ps
`default_nettype none
module tec_pulse_src (
  // clock
  input wire logic clk,
  // command
  input wire logic go,
  input wire logic [9:0] half,
  // pin side
  output logic pin = 1'b0,
  output logic done = 1'b0
);
  logic [10:0] age = 11'h000;
  // the caller picks half as at least three sampling clocks
  always @(posedge clk) begin
    done <= 1'b0;
    if (go && !done) begin
      if (age == 11'h000) pin <= 1'b1;
      if (age == {1'b0, half}) pin <= 1'b0;
      if (age == {half, 1'b0}) begin
        done <= 1'b1;
        age <= 11'h000;
      end else begin
        age <= age + 11'h001;
      end
    end
  end
endmodule : tec_pulse_src
`default_nettype wire

/* File: tb/test_timer_event_counter_core.sv */
// Purpose: directed register and event tests of the timer/event counter
// Assumes: 100 MHz sys_clk, register reads valid one cycle after the strobe
// Notes: /4 prescaler gives exact tick counts over fixed windows
`timescale 1ns/1ps
`default_nettype none
`include "tec_consts.svh"
module test_timer_event_counter_core
  import tec_pkg::*;
;
  logic sys_clk;
  logic reset_n;
  tec_bus_req_t bus_req;
  logic [15:0] rdata;
  logic ext_irq_pin;
  logic ext_irq_req;
  logic match_a_irq;
  logic match_b_irq;
  logic go;
  logic [9:0] half;
  logic done;
  logic [15:0] v;
  logic [15:0] c;
  int n_fail = 0;
  int compares = 0;
  int n_ext = 0;
  int n_ma = 0;
  int n0;
  int n_mb = 0;
  int n1;
  tec_core u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
    .ext_irq_pin(ext_irq_pin), .ext_irq_req(ext_irq_req), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq));
  tec_pulse_src u_src (.clk(sys_clk), .go(go), .half(half), .pin(ext_irq_pin), .done(done));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // counted on the falling edge so window ends taken at a rising edge never race
  always @(negedge sys_clk) begin
    if (ext_irq_req === 1'b1) n_ext++;
    if (match_a_irq === 1'b1) n_ma++;
    if (match_b_irq === 1'b1) n_mb++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 d = rdata;
  endtask : rd
  task automatic rx(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rx
  // full pulse on the pin, then a few cycles for the filter to settle
  task automatic pulse(input logic [9:0] h);
    half <= h;
    go <= 1'b1;
    @(posedge sys_clk);
    while (done !== 1'b1) @(posedge sys_clk);
    go <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : pulse
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    bus_req = '0;
    go = 1'b0;
    half = 10'h008;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rx(`TEC_OFF_TIMER_CTRL, 16'h0000);
    rx(`TEC_OFF_PRESCALE_SEL, 16'h0011);
    rx(`TEC_OFF_CAPCMP_CTRL, 16'h0000);
    rx(`TEC_OFF_COUNTER, 16'h0000);
    rx(8'h24, 16'h0000);
    wr(`TEC_OFF_TIMER_CTRL, 16'h00f0);
    repeat (20) @(posedge sys_clk);
    rx(`TEC_OFF_COUNTER, 16'h0000);
    rx(`TEC_OFF_TIMER_CTRL, 16'h00f0);
    wr(`TEC_OFF_PRESCALE_SEL, 16'h0000);
    wr(`TEC_OFF_SAMPLE_SEL, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      wr(`TEC_OFF_TIMER_CTRL, 16'h0000);
      wr(`TEC_OFF_EDGE_MODE, 16'(m));
      wr(`TEC_OFF_TIMER_CTRL, 16'h0008);
      n0 = n_ext;
      repeat (3) pulse(10'h008);
      rx(`TEC_OFF_COUNTER, (m >= 2) ? 16'h0005 : 16'h0002);
      chk(16'(n_ext - n0), (m >= 2) ? 16'h0006 : 16'h0003);
    end
    wr(`TEC_OFF_TIMER_CTRL, 16'h0008);
    pulse(10'h008);
    rx(`TEC_OFF_COUNTER, 16'h0007);
    wr(`TEC_OFF_TIMER_CTRL, 16'h0000);
    rx(`TEC_OFF_COUNTER, 16'h0000);
    wr(`TEC_OFF_TIMER_CTRL, 16'h0008);
    pulse(10'h008);
    rx(`TEC_OFF_COUNTER, 16'h0001);
    wr(`TEC_OFF_EDGE_MODE, 16'h0001);
    for (int s = 1; s < 4; s++) begin
      wr(`TEC_OFF_SAMPLE_SEL, 16'(s));
      n0 = n_ext;
      pulse(10'(4 << (s + 4)));
      chk(16'(n_ext - n0), 16'h0001);
    end
    wr(`TEC_OFF_SAMPLE_SEL, 16'h0000);
    wr(`TEC_OFF_PRESCALE_SEL, 16'h0001);
    wr(`TEC_OFF_CAPCMP_CTRL, 16'h0004);
    repeat (40) @(posedge sys_clk);
    pulse(10'h008);
    rd(`TEC_OFF_MATCH_B, v);
    rd(`TEC_OFF_CAPTURE_C, c);
    chk(v, c);
    wr(`TEC_OFF_MATCH_B, 16'h0055);
    rx(`TEC_OFF_MATCH_B, c);
    repeat (40) @(posedge sys_clk);
    rx(`TEC_OFF_CAPTURE_C, c);
    wr(`TEC_OFF_CAPCMP_CTRL, 16'h0001);
    wr(`TEC_OFF_MATCH_A, 16'h0005);
    wr(`TEC_OFF_MATCH_B, 16'h0003);
    wr(`TEC_OFF_TIMER_CTRL, 16'h0000);
    wr(`TEC_OFF_TIMER_CTRL, 16'h0008);
    repeat (40) @(posedge sys_clk);
    n0 = n_ma;
    n1 = n_mb;
    repeat (240) @(posedge sys_clk);
    chk(16'(n_ma - n0), 16'h000a);
    chk(16'(n_mb - n1), 16'h000a);
    wr(`TEC_OFF_CAPCMP_CTRL, 16'h0000);
    wr(`TEC_OFF_TIMER_CTRL, 16'h0000);
    wr(`TEC_OFF_TIMER_CTRL, 16'h0008);
    repeat (1100) @(posedge sys_clk);
    rx(`TEC_OFF_TIMER_CTRL, 16'h000c);
    repeat (400) @(posedge sys_clk);
    rx(`TEC_OFF_TIMER_CTRL, 16'h000c);
    wr(`TEC_OFF_TIMER_CTRL, 16'h0008);
    rx(`TEC_OFF_TIMER_CTRL, 16'h0008);
    wr(`TEC_OFF_TIMER_CTRL, 16'h0009);
    repeat (1100) @(posedge sys_clk);
    rd(`TEC_OFF_COUNTER, v);
    chk({15'h0000, v > 16'h00ff}, 16'h0001);
    rx(`TEC_OFF_TIMER_CTRL, 16'h0009);
    end_of_test();
  end
endmodule : test_timer_event_counter_core
`default_nettype wire
